//--- hdl/output_port_defs.vh
`ifndef OUTPUT_PORT_DEFS_VH
`define OUTPUT_PORT_DEFS_VH

`define ADDR_W              12
`define IDX_LOW_NIBBLE      12'h2eb
`define IDX_SPECIAL_NIBBLE  12'h2ec
`define ADDR_LOW_NIBBLE     12'hbac
`define ADDR_SPECIAL_NIBBLE 12'hbb0
`define NIBBLE_RESET        4'h0
`define BIT_BUZZER          0
`define BIT_SERIAL          1
`define BIT_CLOCK           2
`define BIT_INV_BUZZER      3
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10
`define BUZZER_HALF_TICKS   8
`define CNT_W               8

`endif

//--- hdl/tick_divider.v
`timescale 1ns/100ps
// square wave that toggles every HALF ticks; free running, so a gated
// enable elsewhere can cut a half period short
module tick_divider #(
	parameter WIDTH = 8,
	parameter HALF  = 1
) (
	input  wire clk_sys_i, // system clock
	input  wire srst_i,    // synchronous reset
	input  wire tick_i,    // oscillator half-period tick
	output reg  wave_o     // divided square wave
);

	// the count is cut to the counter width on purpose
	localparam integer     LAST_I = HALF - 1;
	localparam [WIDTH-1:0] LAST   = LAST_I[WIDTH-1:0];

	reg [WIDTH-1:0] cnt;

	always @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			cnt    <= {WIDTH{1'b0}};
			wave_o <= 1'b0;
		end
		else if (tick_i)
		begin
			if (cnt == LAST)
			begin
				cnt    <= {WIDTH{1'b0}};
				wave_o <= ~wave_o;
			end
			else
				cnt <= cnt + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

endmodule // tick_divider

//--- hdl/output_port_special_func.v
`timescale 1ns/100ps
`include "output_port_defs.vh"

module output_port_special_func #(
	parameter SEL_BUZZER     = 1, // special bit 0 is buzzer output
	parameter SEL_SERIAL     = 1, // special bit 1 is serial run indicator
	parameter SEL_CLOCK      = 1, // special bit 2 is divided clock output
	parameter SEL_INV_BUZZER = 1, // special bit 3 is inverted buzzer
	parameter INV_SHARED     = 0, // 1: buzzer bit controls both buzzer pins
	parameter CLK_DIV_LOG2   = 0, // clock output divide factor 2**n, n = 0..7
	parameter BUZZER_HALF    = `BUZZER_HALF_TICKS
) (
	input  wire                 clk_sys_i,         // system clock, 100 MHz
	input  wire                 srst_i,            // synchronous reset, active high
	input  wire                 osc_tick_i,        // one pulse per oscillator half period
	input  wire                 serial_run_i,      // serial interface running
	input  wire [`ADDR_W-1:0]   s_axi_awaddr_i,    // write address
	input  wire                 s_axi_awvalid_i,   // write address valid
	output reg                  s_axi_awready_o,   // write address ready
	input  wire [31:0]          s_axi_wdata_i,     // write data
	input  wire [3:0]           s_axi_wstrb_i,     // write byte strobes
	input  wire                 s_axi_wvalid_i,    // write data valid
	output reg                  s_axi_wready_o,    // write data ready
	output reg  [1:0]           s_axi_bresp_o,     // write response
	output reg                  s_axi_bvalid_o,    // write response valid
	input  wire                 s_axi_bready_i,    // write response ready
	input  wire [`ADDR_W-1:0]   s_axi_araddr_i,    // read address
	input  wire                 s_axi_arvalid_i,   // read address valid
	output reg                  s_axi_arready_o,   // read address ready
	output reg  [31:0]          s_axi_rdata_o,     // read data
	output reg  [1:0]           s_axi_rresp_o,     // read response
	output reg                  s_axi_rvalid_o,    // read data valid
	input  wire                 s_axi_rready_i,    // read data ready
	output reg  [3:0]           plain_out_pins_o,  // pins of the plain nibble
	output reg  [3:0]           special_pins_o,    // pins of the special nibble
	output reg                  config_reject_o    // inverted buzzer option rejected
);

	// inverted buzzer only exists next to a true buzzer output
	localparam INV_OK = (SEL_INV_BUZZER != 0) && (SEL_BUZZER != 0);
	localparam REJECT = (SEL_INV_BUZZER != 0) && (SEL_BUZZER == 0);
	localparam CLK_HALF = 1 << CLK_DIV_LOG2;

	reg  [3:0]         plain_out_bits_a;
	reg  [3:0]         special_bits;
	reg                aw_held;
	reg                w_held;
	reg  [`ADDR_W-1:0] aw_addr;
	reg  [31:0]        w_data;
	reg  [3:0]         w_strb;
	reg  [31:0]        next_rdata;
	reg  [1:0]         next_rresp;
	reg  [3:0]         next_special;
	reg  [3:0]         next_pins;
	wire               buzzer_wave_out;
	wire               divided_clock_out;
	wire               buzzer_ctrl_bit;
	wire               serial_status_bit;
	wire               clock_out_ctrl_bit;
	wire               inv_buzzer_ctrl_bit;
	wire               inv_control;
	wire               do_write;
	wire               aw_take;
	wire               w_take;
	wire               b_done;
	wire               ar_take;
	wire               r_done;
	wire               hit_low_w;
	wire               hit_special_w;
	wire               hit_low_r;
	wire               hit_special_r;
	wire               low_wr;
	wire               special_wr;
	reg                pin_buzzer;
	reg                pin_serial;
	reg                pin_clock;
	reg                pin_inv;

	assign buzzer_ctrl_bit     = special_bits[`BIT_BUZZER];
	assign serial_status_bit   = special_bits[`BIT_SERIAL];
	assign clock_out_ctrl_bit  = special_bits[`BIT_CLOCK];
	assign inv_buzzer_ctrl_bit = special_bits[`BIT_INV_BUZZER];

	// shared mode lets the true buzzer bit switch both pins with one write
	assign inv_control = (INV_SHARED != 0) ? buzzer_ctrl_bit : inv_buzzer_ctrl_bit;

	assign do_write = aw_held && w_held && !s_axi_bvalid_o;

	assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
	assign w_take  = s_axi_wvalid_i && s_axi_wready_o;
	assign b_done  = s_axi_bvalid_o && s_axi_bready_i;
	assign ar_take = s_axi_arvalid_i && s_axi_arready_o;
	assign r_done  = s_axi_rvalid_o && s_axi_rready_i;

	// the write address is decoded from the held copy, never from the live bus
	assign hit_low_w     = (aw_addr == `ADDR_LOW_NIBBLE);
	assign hit_special_w = (aw_addr == `ADDR_SPECIAL_NIBBLE);
	assign hit_low_r     = (s_axi_araddr_i == `ADDR_LOW_NIBBLE);
	assign hit_special_r = (s_axi_araddr_i == `ADDR_SPECIAL_NIBBLE);

	// a cleared byte strobe still completes the write, it only skips storage
	assign low_wr     = do_write && w_strb[0] && hit_low_w;
	assign special_wr = do_write && w_strb[0] && hit_special_w;

	// buzzer tone from the low-speed oscillator only
	tick_divider #(
		.WIDTH (`CNT_W),
		.HALF  (BUZZER_HALF)
	) u_buzzer_div (
		.clk_sys_i (clk_sys_i),
		.srst_i    (srst_i),
		.tick_i    (osc_tick_i),
		.wave_o    (buzzer_wave_out)
	);

	tick_divider #(
		.WIDTH (`CNT_W),
		.HALF  (CLK_HALF)
	) u_clock_div (
		.clk_sys_i (clk_sys_i),
		.srst_i    (srst_i),
		.tick_i    (osc_tick_i),
		.wave_o    (divided_clock_out)
	);

	// address side: held until the paired data word has been applied
	always @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			aw_held         <= 1'b0;
			aw_addr         <= {`ADDR_W{1'b0}};
			s_axi_awready_o <= 1'b0;
		end
		else if (do_write)
		begin
			aw_held         <= 1'b0;
			s_axi_awready_o <= 1'b1;
		end
		else if (aw_take)
		begin
			aw_held         <= 1'b1;
			aw_addr         <= s_axi_awaddr_i;
			s_axi_awready_o <= 1'b0;
		end
		else if (!aw_held)
			s_axi_awready_o <= 1'b1;
	end

	// data side: taken before or after the address, either order works
	always @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			w_held         <= 1'b0;
			w_data         <= 32'h0000_0000;
			w_strb         <= 4'h0;
			s_axi_wready_o <= 1'b0;
		end
		else if (do_write)
		begin
			w_held         <= 1'b0;
			s_axi_wready_o <= 1'b1;
		end
		else if (w_take)
		begin
			w_held         <= 1'b1;
			w_data         <= s_axi_wdata_i;
			w_strb         <= s_axi_wstrb_i;
			s_axi_wready_o <= 1'b0;
		end
		else if (!w_held)
			s_axi_wready_o <= 1'b1;
	end

	// response only after both halves are held; one write in flight at a time
	always @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= `RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid_o <= 1'b1;
			if (hit_low_w || hit_special_w)
				s_axi_bresp_o <= `RESP_OKAY;
			else
				s_axi_bresp_o <= `RESP_SLVERR;
		end
		else if (b_done)
			s_axi_bvalid_o <= 1'b0;
	end

	// special nibble write; the serial bit keeps its value when it is a status
	always @*
	begin
		next_special = special_bits;
		next_special[`BIT_BUZZER]     = w_data[`BIT_BUZZER];
		next_special[`BIT_CLOCK]      = w_data[`BIT_CLOCK];
		next_special[`BIT_INV_BUZZER] = w_data[`BIT_INV_BUZZER];
		if (SEL_SERIAL == 0)
			next_special[`BIT_SERIAL] = w_data[`BIT_SERIAL];
		else
			next_special[`BIT_SERIAL] = special_bits[`BIT_SERIAL];
	end

	always @(posedge clk_sys_i)
	begin
		if (srst_i)
			plain_out_bits_a <= `NIBBLE_RESET;
		else if (low_wr)
			plain_out_bits_a <= w_data[3:0];
	end

	always @(posedge clk_sys_i)
	begin
		if (srst_i)
			special_bits <= `NIBBLE_RESET;
		else if (special_wr)
			special_bits <= next_special;
	end

	// read decode; upper bits read as zero
	always @*
	begin
		next_rdata = 32'h0000_0000;
		next_rresp = `RESP_OKAY;
		if (hit_low_r)
			next_rdata[3:0] = plain_out_bits_a;
		else if (hit_special_r)
		begin
			next_rdata[3:0] = special_bits;
			if (SEL_SERIAL != 0)
				next_rdata[`BIT_SERIAL] = serial_run_i;
		end
		else
			next_rresp = `RESP_SLVERR;
	end

	// one read at a time: the address is refused until the data is taken
	always @(posedge clk_sys_i)
	begin
		if (srst_i)
			s_axi_arready_o <= 1'b0;
		else if (ar_take)
			s_axi_arready_o <= 1'b0;
		else if (r_done || !s_axi_rvalid_o)
			s_axi_arready_o <= 1'b1;
	end

	always @(posedge clk_sys_i)
	begin
		if (srst_i)
			s_axi_rvalid_o <= 1'b0;
		else if (ar_take)
			s_axi_rvalid_o <= 1'b1;
		else if (r_done)
			s_axi_rvalid_o <= 1'b0;
	end

	// data and response are captured once, so they stand while rvalid waits
	always @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= `RESP_OKAY;
		end
		else if (ar_take)
		begin
			s_axi_rdata_o <= next_rdata;
			s_axi_rresp_o <= next_rresp;
		end
	end

	// pin mux; enables gate the free-running waves directly, so a pin may
	// show a short pulse when it is switched
	always @*
	begin
		if (SEL_BUZZER != 0)
			pin_buzzer = buzzer_ctrl_bit & buzzer_wave_out;
		else
			pin_buzzer = buzzer_ctrl_bit;
	end

	// the status pin follows the live run state, not the stored bit
	always @*
	begin
		if (SEL_SERIAL != 0)
			pin_serial = serial_run_i;
		else
			pin_serial = serial_status_bit;
	end

	always @*
	begin
		if (SEL_CLOCK != 0)
			pin_clock = clock_out_ctrl_bit & divided_clock_out;
		else
			pin_clock = clock_out_ctrl_bit;
	end

	// a rejected inverted buzzer falls back to a plain level from its bit
	always @*
	begin
		if (INV_OK)
			pin_inv = inv_control & ~buzzer_wave_out;
		else
			pin_inv = inv_buzzer_ctrl_bit;
	end

	always @*
	begin
		next_pins = {pin_inv, pin_clock, pin_serial, pin_buzzer};
	end

	always @(posedge clk_sys_i)
	begin
		if (srst_i)
			plain_out_pins_o <= `NIBBLE_RESET;
		else
			plain_out_pins_o <= plain_out_bits_a;
	end

	always @(posedge clk_sys_i)
	begin
		if (srst_i)
			special_pins_o <= `NIBBLE_RESET;
		else
			special_pins_o <= next_pins;
	end

	// the option check is static, but a flop keeps every output registered
	always @(posedge clk_sys_i)
	begin
		if (srst_i)
			config_reject_o <= 1'b0;
		else
			config_reject_o <= REJECT;
	end

endmodule // output_port_special_func

//--- tb/output_port_checker_assertions.sv
`timescale 1ns/100ps
module output_port_checker (
	input wire       clk_sys_i,        // clock
	input wire       srst_i,           // reset
	input wire       osc_tick_i,       // osc tick
	input wire       serial_run_i,     // serial running
	input wire       s_axi_bvalid_o,   // bvalid
	input wire       s_axi_bready_i,   // bready
	input wire       s_axi_rvalid_o,   // rvalid
	input wire       s_axi_rready_i,   // rready
	input wire [3:0] plain_out_pins_o, // plain pins
	input wire [3:0] special_pins_o,   // special pins
	input wire       config_reject_o   // reject flag
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	reg [7:0] hi_ticks;
	// ticks while the buzzer pin is high; a half period is 8 ticks at most
	always @(posedge clk_sys_i)
	begin
		if (srst_i || !special_pins_o[0])
			hi_ticks <= 8'h00;
		else if (osc_tick_i)
			hi_ticks <= hi_ticks + 8'h01;
	end
	property p_rst; $fell(srst_i) |-> plain_out_pins_o == 4'h0 && special_pins_o == 4'h0; endproperty
	a_rst: assert property (p_rst) else $error("pins not cleared");
	property p_ser; !$past(srst_i) |-> special_pins_o[1] == $past(serial_run_i); endproperty
	a_ser: assert property (p_ser) else $error("serial pin wrong");
	property p_inv; !config_reject_o && special_pins_o[3] |-> !special_pins_o[0]; endproperty
	a_inv: assert property (p_inv) else $error("buzzer pins not inverse");
	property p_bdrop; s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o; endproperty
	a_bdrop: assert property (p_bdrop) else $error("bvalid stuck");
	property p_rdrop; s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o; endproperty
	a_rdrop: assert property (p_rdrop) else $error("rvalid stuck");
	property p_plain; !$past(srst_i) && $changed(plain_out_pins_o) |-> $past(s_axi_bvalid_o); endproperty
	a_plain: assert property (p_plain) else $error("plain pins moved alone");
	property p_tick; hi_ticks <= 8'd8; endproperty
	a_tick: assert property (p_tick) else $error("buzzer half too long");
	property p_clk; $rose(special_pins_o[2]) |-> $past(osc_tick_i, 2) || $past(osc_tick_i) || $past(s_axi_bvalid_o); endproperty
	a_clk: assert property (p_clk) else $error("clock pin rose off tick");
endmodule // output_port_checker

//--- tb/load_model.sv
`timescale 1ns/100ps
module load_model (
	input  wire       clk_sys_i, // clock
	input  wire       clr_i,     // clear counts
	input  wire [3:0] pins_i,    // special pins
	output reg  [7:0] bz_o,      // buzzer rises
	output reg  [7:0] ck_o,      // clock rises
	output reg  [7:0] iv_o       // inverted rises
);
	reg [3:0] last;
	// enable glitches count like any edge, as a real load would see them
	always @(posedge clk_sys_i)
	begin
		last <= pins_i;
		bz_o <= clr_i ? 8'h00 : bz_o + {7'h0, pins_i[0] & ~last[0]};
		ck_o <= clr_i ? 8'h00 : ck_o + {7'h0, pins_i[2] & ~last[2]};
		iv_o <= clr_i ? 8'h00 : iv_o + {7'h0, pins_i[3] & ~last[3]};
	end
endmodule // load_model

//--- tb/tb_top.sv
`timescale 1ns/100ps
`include "output_port_defs.vh"
module tb_top;
	reg        clk_sys_i = 1'b0, srst_i = 1'b1, tick = 1'b0, ser = 1'b0, clr = 1'b1;
	reg        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
	reg [11:0] awa = 12'h000, ara = 12'h000;
	reg [31:0] wd = 32'h0;
	reg [3:0]  ws = 4'h0;
	reg [1:0]  tc = 2'h0;
	wire       awr, wrdy, bv, arr, rv, rej;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	wire [3:0] pp, sp;
	wire [7:0] nbz, nck, niv;
	wire [3:0] sp2;
	wire [7:0] niv2;
	integer    n_mismatch = 0, checked = 0;
	output_port_special_func i_dut (
		.clk_sys_i(clk_sys_i), .srst_i(srst_i), .osc_tick_i(tick), .serial_run_i(ser),
		.s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
		.s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy),
		.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy),
		.plain_out_pins_o(pp), .special_pins_o(sp), .config_reject_o(rej));
	load_model i_load (.clk_sys_i(clk_sys_i), .clr_i(clr), .pins_i(sp), .bz_o(nbz),
		.ck_o(nck), .iv_o(niv));
	// second copy in shared mode: the true buzzer bit switches both buzzer pins
	output_port_special_func #(.INV_SHARED(1)) i_dut_shared (
		.clk_sys_i(clk_sys_i), .srst_i(srst_i), .osc_tick_i(tick), .serial_run_i(ser),
		.s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(),
		.s_axi_bresp_o(), .s_axi_bvalid_o(), .s_axi_bready_i(brdy),
		.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(),
		.s_axi_rdata_o(), .s_axi_rresp_o(), .s_axi_rvalid_o(), .s_axi_rready_i(rrdy),
		.plain_out_pins_o(), .special_pins_o(sp2), .config_reject_o());
	load_model i_load_shared (.clk_sys_i(clk_sys_i), .clr_i(clr), .pins_i(sp2), .bz_o(),
		.ck_o(), .iv_o(niv2));
	initial
	begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// oscillator half-period tick every fourth cycle
	always @(posedge clk_sys_i)
	begin
		tc <= tc + 2'h1;
		tick <= (tc == 2'h3);
	end
	task results;
	begin
		if (n_mismatch == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	task chk(input [31:0] got, input [31:0] lo, input [31:0] hi);
	begin
		checked = checked + 1;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			n_mismatch = n_mismatch + 1;
			$display("Error at %0t: got %h expected %h", $time, got, lo);
		end
	end
	endtask
	task wr(input [11:0] a, input [3:0] v, input s, input [1:0] er);
		reg ad, dd;
	begin
		awa <= a;
		wd <= {28'h0, v};
		ws <= {3'h0, s};
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		ad = 1'b0;
		dd = 1'b0;
		while (!(ad && dd))
		begin
			@(posedge clk_sys_i);
			if (awr)
				awv <= 1'b0;
			if (wrdy)
				wv <= 1'b0;
			ad = ad | awr;
			dd = dd | wrdy;
		end
		@(posedge clk_sys_i);
		while (!bv)
			@(posedge clk_sys_i);
		chk({30'h0, br}, {30'h0, er}, {30'h0, er});
	end
	endtask
	task rd(input [11:0] a, input [31:0] ev, input [1:0] er);
	begin
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		@(posedge clk_sys_i);
		while (!arr)
			@(posedge clk_sys_i);
		arv <= 1'b0;
		@(posedge clk_sys_i);
		while (!rv)
			@(posedge clk_sys_i);
		chk(rdat, ev, ev);
		chk({30'h0, rr}, {30'h0, er}, {30'h0, er});
	end
	endtask
	// buzzer period 64 cycles, clock output period 8 cycles at these tick rates
	task fn(input [3:0] v);
	begin
		wr(`ADDR_SPECIAL_NIBBLE, v, 1'b1, `RESP_OKAY);
		clr <= 1'b1;
		@(posedge clk_sys_i);
		clr <= 1'b0;
		repeat (256)
			@(posedge clk_sys_i);
		chk({24'h0, nbz}, v[0] ? 3 : 0, v[0] ? 5 : 0);
		chk({24'h0, nck}, v[2] ? 31 : 0, v[2] ? 34 : 0);
		chk({24'h0, niv}, v[3] ? 3 : 0, v[3] ? 5 : 0);
		chk({24'h0, niv2}, v[0] ? 3 : 0, v[0] ? 5 : 0);
	end
	endtask
	initial
	begin
		repeat (10)
			@(posedge clk_sys_i);
		srst_i <= 1'b0;
		clr <= 1'b0;
		@(posedge clk_sys_i);
		chk({28'h0, pp}, 0, 0);
		rd(`ADDR_LOW_NIBBLE, 32'h0, `RESP_OKAY);
		rd(`ADDR_SPECIAL_NIBBLE, 32'h0, `RESP_OKAY);
		chk({31'h0, rej}, 0, 0);
		wr(`ADDR_LOW_NIBBLE, 4'ha, 1'b1, `RESP_OKAY);
		wr(`ADDR_LOW_NIBBLE, 4'h5, 1'b0, `RESP_OKAY);
		rd(`ADDR_LOW_NIBBLE, 32'ha, `RESP_OKAY);
		chk({28'h0, pp}, 32'ha, 32'ha);
		rd(12'h000, 32'h0, `RESP_SLVERR);
		wr(12'h004, 4'hf, 1'b1, `RESP_SLVERR);
		ser <= 1'b1;
		wr(`ADDR_SPECIAL_NIBBLE, 4'h0, 1'b1, `RESP_OKAY);
		rd(`ADDR_SPECIAL_NIBBLE, 32'h2, `RESP_OKAY);
		chk({31'h0, sp[1]}, 1, 1);
		ser <= 1'b0;
		wr(`ADDR_SPECIAL_NIBBLE, 4'h2, 1'b1, `RESP_OKAY);
		rd(`ADDR_SPECIAL_NIBBLE, 32'h0, `RESP_OKAY);
		fn(4'h1);
		fn(4'h9);
		fn(4'h4);
		fn(4'h0);
		chk({28'h0, sp}, 0, 0);
		results;
	end
	initial
	begin
		repeat (5000)
			@(posedge clk_sys_i);
		n_mismatch = n_mismatch + 1;
		results;
	end
endmodule // tb_top
bind output_port_special_func output_port_checker i_chk (.clk_sys_i(clk_sys_i),
	.srst_i(srst_i), .osc_tick_i(osc_tick_i), .serial_run_i(serial_run_i),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.plain_out_pins_o(plain_out_pins_o), .special_pins_o(special_pins_o),
	.config_reject_o(config_reject_o));
